// file: verilog/gfs_top.sv
// pin function select for two general-purpose pins, with register port and interrupt
// assumes pins synchronous to clk; register strobes one cycle, never both at once
//
// Operation
// [RL1] pull-up on only when enabled and pin is a digital input
// [RL2] config bits 7:6 hold read/write drive strength
// [RL3] low five bits pick the role; pin zero code 0 outputs reset indication
// [RL4] pin one code 0 outputs inverted reset indication
// [RL5] code 1 outputs wake-up timer expired flag
// [RL6] code 2 outputs low-battery indication
// [RL7] code 3 direct input, code 10 direct output from register bit
// [RL8] codes 4,5,6 interrupt input on falling, rising, any edge
// [RL9] code 7 analog converter input, code 14 reference out; no digital drive
// [RL10] code 15 outputs transmit clock, code 16 takes transmit data
// [RL11] code 17 input requests packet retransmission
// [RL12] code 18 outputs high while transmitting
// [RL13] code 19 outputs transmit FIFO almost-full
// [RL14] host must not program reserved codes 8,9,11-13,20-28
// [RL15] code 29 drives high, above drives low
// [RL16] per-pin interrupt status readable by host
// [RL17] per-pin bit sets direct output level or reads direct input level
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none

`include "gfs_params.svh"

module gfs_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // internal sources
    input wire logic por_flag,
    input wire logic wakeup_expired,
    input wire logic low_battery,
    input wire logic tx_data_clk,
    input wire logic tx_state,
    input wire logic fifo_almost_full,
    // pins
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe_n,
    output logic [1:0] pin_pullup_on,
    output logic [1:0] pin_analog_sel,
    output logic [3:0] pin_drive_strength,
    // modulator side
    output logic tx_direct_data,
    output logic retx_request,
    // interrupt
    output logic irq
);

    gfs_pkg::gfs_byte_t pin0_config_reg;
    gfs_pkg::gfs_byte_t pin1_config_reg;
    logic [1:0] direct_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] pin_level_reg;
    logic [1:0] ev;
    logic [1:0] is_din;
    logic [1:0] txd;
    logic [1:0] rtx;

    gfs_pin_if pif [2] ();

    // ********************************************
    // pin slices
    // ********************************************
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_pin
            gfs_pin_slice #(
                .INVERT_POR(i == 1)
            ) u_slice (
                .clk(clk),
                .rst(rst),
                .por_flag(por_flag),
                .wakeup_expired(wakeup_expired),
                .low_battery(low_battery),
                .tx_data_clk(tx_data_clk),
                .tx_state(tx_state),
                .fifo_almost_full(fifo_almost_full),
                .p(pif[i])
            );
            assign pif[i].func = (i == 0) ? pin0_config_reg[`GFS_FN_HI:`GFS_FN_LO]
                                          : pin1_config_reg[`GFS_FN_HI:`GFS_FN_LO];
            assign pif[i].pullup_cfg = (i == 0) ? pin0_config_reg[`GFS_PUP_BIT]
                                                : pin1_config_reg[`GFS_PUP_BIT];
            assign pif[i].direct_level = direct_reg[i];
            assign pif[i].pin_in = pin_in[i];
            assign pin_out[i] = pif[i].pin_out;
            assign pin_oe_n[i] = pif[i].pin_oe_n;
            assign pin_pullup_on[i] = pif[i].pullup_on;
            assign pin_analog_sel[i] = pif[i].analog_sel;
            assign ev[i] = pif[i].irq_event;
            assign txd[i] = pif[i].txdata;
            assign rtx[i] = pif[i].retx_req;
            assign is_din[i] = (pif[i].func == gfs_pkg::FN_DIN);
        end
    endgenerate

    assign pin_drive_strength = {pin1_config_reg[`GFS_DRV_HI:`GFS_DRV_LO],
                                 pin0_config_reg[`GFS_DRV_HI:`GFS_DRV_LO]}; // [RL2]
    assign tx_direct_data = |txd; // [RL10]
    assign retx_request = |rtx; // [RL11]

    // ********************************************
    // configuration registers
    // ********************************************
    // reserved codes are stored as written; the host keeps clear of them [RL14]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin0_config_reg <= `GFS_CFG_RESET;
            pin1_config_reg <= `GFS_CFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `GFS_OFF_PIN0_CFG) begin
                pin0_config_reg <= reg_wdata; // [RL2]
            end
            if (reg_addr == `GFS_OFF_PIN1_CFG) begin
                pin1_config_reg <= reg_wdata; // [RL2]
            end
        end
    end

    // ********************************************
    // direct level and pin sampling
    // ********************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            direct_reg <= `GFS_DIO_RESET;
        end else if (reg_wr && reg_addr == `GFS_OFF_DIO) begin
            direct_reg <= reg_wdata[1:0]; // [RL17]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_level_reg <= 2'h0;
        end else begin
            pin_level_reg <= pin_in;
        end
    end

    // ********************************************
    // interrupt status and mask
    // ********************************************
    // an edge in the same cycle as a write-one-clear keeps its bit set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((reg_wr && reg_addr == `GFS_OFF_IRQ_STAT)
                            ? reg_wdata[1:0] : 2'h0)) | ev; // [RL8] [RL16]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= 2'h0;
        end else if (reg_wr && reg_addr == `GFS_OFF_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ********************************************
    // read port
    // ********************************************
    // read data stand only in the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `GFS_OFF_PIN0_CFG: reg_rdata <= pin0_config_reg;
                `GFS_OFF_PIN1_CFG: reg_rdata <= pin1_config_reg;
                `GFS_OFF_DIO: reg_rdata <= {2'h0, irq_stat_reg, 2'h0,
                    (is_din & pin_level_reg) | (~is_din & direct_reg)}; // [RL16] [RL17]
                `GFS_OFF_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_reg}; // [RL16]
                `GFS_OFF_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : gfs_top

`default_nettype wire

// file: verilog/gfs_params.svh
// register offsets, field positions and reset values of the pin function select block
// assumes inclusion by bare name from design files
`ifndef GFS_PARAMS_SVH
`define GFS_PARAMS_SVH

`define GFS_OFF_PIN0_CFG 8'h0B
`define GFS_OFF_PIN1_CFG 8'h0C
`define GFS_OFF_DIO 8'h0E
`define GFS_OFF_IRQ_STAT 8'h10
`define GFS_OFF_IRQ_MASK 8'h11

`define GFS_DRV_HI 7
`define GFS_DRV_LO 6
`define GFS_PUP_BIT 5
`define GFS_FN_HI 4
`define GFS_FN_LO 0

`define GFS_CFG_RESET 8'h00
`define GFS_DIO_RESET 2'h0

`endif

// file: verilog/gfs_pkg.sv
// types of the pin function select block
// assumes gfs_params.svh defines the numeric constants
`default_nettype none

package gfs_pkg;

    typedef enum logic [4:0] {
        FN_POR = 5'h00,
        FN_WAKEUP = 5'h01,
        FN_LOWBAT = 5'h02,
        FN_DIN = 5'h03,
        FN_IRQ_FALL = 5'h04,
        FN_IRQ_RISE = 5'h05,
        FN_IRQ_CHG = 5'h06,
        FN_ADC_IN = 5'h07,
        FN_DOUT = 5'h0A,
        FN_VREF = 5'h0E,
        FN_TXCLK = 5'h0F,
        FN_TXDATA = 5'h10,
        FN_RETX = 5'h11,
        FN_TXSTATE = 5'h12,
        FN_ALMFULL = 5'h13,
        FN_VDD = 5'h1D
    } gfs_func_e;

    typedef logic [7:0] gfs_byte_t;

endpackage : gfs_pkg

`default_nettype wire

// file: verilog/gfs_pin_if.sv
// carries one pin's configuration and state between the top and a pin slice
// assumes a single clock domain
`timescale 1ns/1ns
`default_nettype none

interface gfs_pin_if;
    logic [4:0] func;
    logic pullup_cfg;
    logic direct_level;
    logic pin_in;
    logic pin_out;
    logic pin_oe_n;
    logic pullup_on;
    logic analog_sel;
    logic irq_event;
    logic txdata;
    logic retx_req;
    modport top (output func, output pullup_cfg, output direct_level, output pin_in,
                 input pin_out, input pin_oe_n, input pullup_on, input analog_sel,
                 input irq_event, input txdata, input retx_req);
    modport slice (input func, input pullup_cfg, input direct_level, input pin_in,
                   output pin_out, output pin_oe_n, output pullup_on, output analog_sel,
                   output irq_event, output txdata, output retx_req);
endinterface : gfs_pin_if

`default_nettype wire

// file: verilog/gfs_pin_slice.sv
// one pin: function decode, output select, input capture and edge detection
// assumes pin input already synchronous to clk
`timescale 1ns/1ns
`default_nettype none

module gfs_pin_slice #(
    parameter bit INVERT_POR = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // internal sources
    input wire logic por_flag,
    input wire logic wakeup_expired,
    input wire logic low_battery,
    input wire logic tx_data_clk,
    input wire logic tx_state,
    input wire logic fifo_almost_full,
    // pin
    gfs_pin_if.slice p
);

    // ********************************************
    // decode helpers
    // ********************************************
    function automatic logic is_input(input logic [4:0] f);
        case (f)
            5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11: is_input = 1'b1;
            default: is_input = 1'b0;
        endcase
    endfunction : is_input

    logic in_reg;
    logic prev_reg;

    // ********************************************
    // input capture
    // ********************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            in_reg <= p.pin_in;
            prev_reg <= in_reg;
        end
    end

    // ********************************************
    // output and enable select
    // ********************************************
    always_comb begin
        p.pin_out = 1'b0;
        p.pin_oe_n = 1'b0;
        p.analog_sel = 1'b0;
        case (p.func)
            5'h00: p.pin_out = por_flag ^ INVERT_POR; // [RL3] [RL4]
            5'h01: p.pin_out = wakeup_expired; // [RL5]
            5'h02: p.pin_out = low_battery; // [RL6]
            5'h0A: p.pin_out = p.direct_level; // [RL7] [RL17]
            5'h0F: p.pin_out = tx_data_clk; // [RL10]
            5'h12: p.pin_out = tx_state; // [RL12]
            5'h13: p.pin_out = fifo_almost_full; // [RL13]
            5'h1D: p.pin_out = 1'b1; // [RL15]
            5'h07, 5'h0E: begin
                // analog use: digital driver released [RL9]
                p.pin_oe_n = 1'b1;
                p.analog_sel = 1'b1;
            end
            default: begin
                // inputs release the pin; reserved and codes above 29 drive low [RL15]
                p.pin_oe_n = is_input(p.func); // [RL7] [RL8] [RL11]
            end
        endcase
    end

    // ********************************************
    // input functions
    // ********************************************
    assign p.pullup_on = p.pullup_cfg & is_input(p.func); // [RL1]
    assign p.txdata = (p.func == 5'h10) & in_reg; // [RL10]
    assign p.retx_req = (p.func == 5'h11) & in_reg; // [RL11]

    always_comb begin
        case (p.func)
            5'h04: p.irq_event = prev_reg & ~in_reg; // [RL8]
            5'h05: p.irq_event = ~prev_reg & in_reg; // [RL8]
            5'h06: p.irq_event = prev_reg ^ in_reg; // [RL8]
            default: p.irq_event = 1'b0;
        endcase
    end

endmodule : gfs_pin_slice

`default_nettype wire

// file: dv/gfs_top_asserts.sv
// concurrent checks on the top ports of the pin function select
// assumes a bind onto gfs_top and a single clock domain
`timescale 1ns/1ns
`default_nettype none
module gfs_top_asserts (
    // clock and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // sources and pins
    input wire logic por_flag,
    input wire logic wakeup_expired,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] pin_pullup_on,
    input wire logic [3:0] pin_drive_strength
);
    // ********
    // shadow of both config registers
    // ********
    logic [7:0] c0_reg;
    logic [7:0] c1_reg;
    logic [4:0] f0;
    logic [4:0] f1;
    assign f0 = c0_reg[4:0];
    assign f1 = c1_reg[4:0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c0_reg <= 8'h00;
            c1_reg <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h0B) c0_reg <= reg_wdata;
            if (reg_addr == 8'h0C) c1_reg <= reg_wdata;
        end
    end
    // ********
    // properties
    // ********
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd0; reg_rd && reg_addr == 8'h0B; endsequence
    property p_pullup; pin_pullup_on[0] == (c0_reg[5] && f0 inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11}); endproperty
    a_pullup: assert property (p_pullup) else $error("pullup state wrong");
    property p_drive; pin_drive_strength == {c1_reg[7:6], c0_reg[7:6]}; endproperty
    a_drive: assert property (p_drive) else $error("drive strength wrong");
    property p_rdback; s_rd0 |=> reg_rdata == $past(c0_reg); endproperty
    a_rdback: assert property (p_rdback) else $error("config readback wrong");
    property p_por0; f0 == 5'h00 |-> !pin_oe_n[0] && pin_out[0] == por_flag; endproperty
    a_por0: assert property (p_por0) else $error("pin0 reset output wrong");
    property p_por1; f1 == 5'h00 |-> !pin_oe_n[1] && pin_out[1] == !por_flag; endproperty
    a_por1: assert property (p_por1) else $error("pin1 reset output wrong");
    property p_wakeup; f0 == 5'h01 |-> pin_out[0] == wakeup_expired; endproperty
    a_wakeup: assert property (p_wakeup) else $error("wake-up output wrong");
    property p_anlg; f1 == 5'h07 || f1 == 5'h0E |-> pin_oe_n[1] && !pin_pullup_on[1]; endproperty
    a_anlg: assert property (p_anlg) else $error("analog pin driven");
    property p_rail; f0 >= 5'h1D |-> pin_out[0] == (f0 == 5'h1D) && !pin_oe_n[0]; endproperty
    a_rail: assert property (p_rail) else $error("fixed level wrong");
endmodule : gfs_top_asserts
bind gfs_top gfs_top_asserts chk_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .por_flag, .wakeup_expired, .pin_out, .pin_oe_n, .pin_pullup_on, .pin_drive_strength);
`default_nettype wire

// file: dv/gfs_host_model.sv
// host microcontroller side of the two pins
// assumes it samples the pins on clk as the block does
`timescale 1ns/1ns
`default_nettype none
module gfs_host_model (
    // clock
    input wire logic clk,
    // device pins
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] pin_pullup_on,
    // host commands
    input wire logic [1:0] host_drive,
    input wire logic [1:0] host_level,
    output logic [1:0] pin_in
);
    // ********
    // wire level
    // ********
    initial pin_in = 2'h0;
    // a floating pin toggles so a stale level never passes for a driven one
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] <= pin_out[i];
            end else if (host_drive[i]) begin
                pin_in[i] <= host_level[i];
            end else if (pin_pullup_on[i]) begin
                pin_in[i] <= 1'h1;
            end else begin
                pin_in[i] <= ~pin_in[i];
            end
        end
    end
endmodule : gfs_host_model
`default_nettype wire

// file: dv/gfs_top_bench.sv
// self-checking bench of the pin function select top
// assumes the host model drives the pin inputs
`timescale 1ns/1ns
`default_nettype none
module gfs_top_bench;
    typedef struct {logic [4:0] c; logic [5:0] s; logic [7:0] e;} gfs_row_s;
    logic clk;
    logic rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, cfg;
    logic reg_wr, reg_rd, tx_direct_data, retx_request, irq;
    logic [5:0] src;
    logic [1:0] pin_in, pin_out, pin_oe_n, pin_pullup_on, pin_analog_sel, hd, hl;
    logic [3:0] pin_drive_strength;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // code, sources {por,wut,lowbat,txclk,txstate,full}, {out,oe_n,pullup,analog}; no reserved code
    gfs_row_s rows [18] = '{'{5'h00, 6'h20, 8'h40}, '{5'h00, 6'h00, 8'h80}, '{5'h01, 6'h10, 8'hC0},
        '{5'h01, 6'h2F, 8'h00}, '{5'h02, 6'h08, 8'hC0}, '{5'h0F, 6'h04, 8'hC0}, '{5'h12, 6'h02, 8'hC0},
        '{5'h13, 6'h01, 8'hC0}, '{5'h1D, 6'h00, 8'hC0}, '{5'h1F, 6'h3F, 8'h00}, '{5'h03, 6'h00, 8'h3C},
        '{5'h04, 6'h00, 8'h3C}, '{5'h05, 6'h00, 8'h3C}, '{5'h06, 6'h00, 8'h3C}, '{5'h10, 6'h00, 8'h3C},
        '{5'h11, 6'h00, 8'h3C}, '{5'h07, 6'h00, 8'h33}, '{5'h0E, 6'h00, 8'h33}};
    gfs_top dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .por_flag(src[5]),
        .wakeup_expired(src[4]), .low_battery(src[3]), .tx_data_clk(src[2]), .tx_state(src[1]),
        .fifo_almost_full(src[0]), .pin_in, .pin_out, .pin_oe_n, .pin_pullup_on, .pin_analog_sel,
        .pin_drive_strength, .tx_direct_data, .retx_request, .irq);
    gfs_host_model host_u (.clk, .pin_out, .pin_oe_n, .pin_pullup_on, .host_drive(hd), .host_level(hl), .pin_in);
    // ********
    // bus and check tasks
    // ********
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        v = reg_rdata;
    endtask : rd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    // ********
    // clock, hang limit and sequence
    // ********
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        rst = 1'h1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        src = 6'h00;
        hd = 2'h0;
        hl = 2'h0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        chk(8'(pin_oe_n), 8'h00);
        rd(8'h0B, d);
        chk(d, 8'h00);
        rd(8'h20, d);
        chk(d, 8'h00);
        foreach (rows[i]) begin
            cfg = {i[1:0], 1'h1, rows[i].c};
            wr(8'h0B, cfg);
            wr(8'h0C, cfg);
            src <= rows[i].s;
            repeat (2) @(negedge clk);
            chk(8'({pin_oe_n, pin_pullup_on, pin_analog_sel}), 8'(rows[i].e[5:0]));
            if (rows[i].e[5:4] == 2'h0) begin
                chk(8'(pin_out), 8'(rows[i].e[7:6]));
            end
            chk(8'(pin_drive_strength), 8'({i[1:0], i[1:0]}));
            rd(8'h0C, d);
            chk(d, cfg);
        end
        wr(8'h0B, 8'h0A);
        wr(8'h0C, 8'h0A);
        wr(8'h0E, 8'h01);
        @(negedge clk);
        chk(8'({pin_oe_n, pin_out}), 8'h01);
        wr(8'h0B, 8'h03);
        wr(8'h0C, 8'h03);
        hd <= 2'h3;
        hl <= 2'h2;
        repeat (3) @(posedge clk);
        rd(8'h0E, d);
        chk(d & 8'h03, 8'h02);
        wr(8'h0B, 8'h04);
        wr(8'h0C, 8'h06);
        hl <= 2'h3;
        wr(8'h11, 8'h03);
        wr(8'h10, 8'h03);
        @(negedge clk);
        chk(8'(irq), 8'h00);
        hl <= 2'h0;
        repeat (4) @(negedge clk);
        chk(8'(irq), 8'h01);
        rd(8'h10, d);
        chk(d, 8'h03);
        rd(8'h0E, d);
        chk(d & 8'h30, 8'h30);
        wr(8'h0B, 8'h05);
        wr(8'h10, 8'h03);
        hl <= 2'h1;
        repeat (4) @(negedge clk);
        rd(8'h10, d);
        chk(d, 8'h01);
        wr(8'h11, 8'h00);
        @(negedge clk);
        chk(8'(irq), 8'h00);
        // host sets the data and retransmit levels with the transmit clock held low, not paced by its edges
        wr(8'h0B, 8'h10);
        wr(8'h0C, 8'h11);
        hl <= 2'h1;
        repeat (4) @(negedge clk);
        chk(8'({tx_direct_data, retx_request}), 8'h02);
        hl <= 2'h2;
        repeat (4) @(negedge clk);
        chk(8'({tx_direct_data, retx_request}), 8'h01);
        rst <= 1'h1;
        @(negedge clk);
        rst <= 1'h0;
        rd(8'h0C, d);
        chk(d, 8'h00);
        chk(8'({pin_oe_n, pin_out, irq}), 8'h04);
        final_report();
    end
endmodule : gfs_top_bench
`default_nettype wire
